// File: src/bfp_pkg.sv
// Constants, carriers and state codes for the buck fault sequencer
package bfp_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25; // System clock rate
  localparam int PG_DG_NS = 20000; // Supply-ok deglitch, ns
  localparam int PG_DG_CYC = (PG_DG_NS * CLK_MHZ + 999) / 1000;
  localparam int OV_DG_NS = 10000; // Overvoltage deglitch, ns
  localparam int OV_DG_CYC = (OV_DG_NS * CLK_MHZ + 999) / 1000;
  localparam int HIC_US = 5000; // Hiccup delay, us
  localparam int HIC_CYC = HIC_US * CLK_MHZ;
  localparam int BLANK_NS = 20; // Least blanking time, ns
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int EN_DLY_CYC = 512; // Internal enable delay
  localparam int SS_STEPS = 128; // Soft-start levels
  localparam int SS_STEP_CYC = 4; // Clocks per soft-start level
  localparam int CL_WIN = 32; // Current-limit window
  localparam int CL_HEAVY = 5; // Events that force hiccup
  localparam int TW = 17; // Timer width
  localparam int DW = 9; // Deglitch counter width
  localparam logic [7:0] SS_RST = 8'h00; // Soft-start count at reset
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic uvt_good; // under_threshold_compare: level good
    logic over_threshold_compare; // over_threshold_compare: raw overvoltage
    logic cl; // current_limit_event comparator
    logic neg; // switch_node above 100 mV
    logic ot_hot; // Die above 150 C
    logic ot_cool; // Die back below trip minus hysteresis
    logic lockout_ok; // line_lockout_enable released
    logic pwm; // Modulator demand
    logic ss_at_fb; // Soft-start level reached feedback_input
    logic hs_off; // high_side_gate sensed off
    logic ls_off; // low_side_gate sensed off
  } bfp_sense_t;
  typedef struct packed {
    logic hs; // high_side_gate enable
    logic ls; // low_side_gate enable
  } bfp_gate_t;
  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    S_OFF = 7'h01, S_DLY = 7'h02, S_SS = 7'h04, S_RUN = 7'h08,
    S_HIC = 7'h10, S_NHIC = 7'h20, S_TSD = 7'h40
  } bfp_state_t;
endpackage

// File: src/bfp_fault_seq.sv
// Fault supervision, gate enables and supply-ok for a buck controller
// Summary of operation
// - Supply-ok low on any fault or not-running
// - Supply-ok filtered by 20 us deglitch
// - Soft-start supply-ok needs count 128 and level good
// - Comparator watches soft-start until first pulse
// - Over-temperature: gates off, discharge soft-start
// - Cooled by hysteresis: auto restart soft-start
// - Current limit ends pulse, low side on
// - Five events in 32 clocks: hiccup
// - Event counter advances on next edge
// - Hiccup holds gates off 5 ms, restarts
// - Negative limit only with raw overvoltage
// - Overvoltage flag deglitched 10 us
// - Negative limit: low side off, 5 ms hiccup
// - Switch node trip turns low side off
// - Negative compare blanked after low-side, pwm rise
// - Undervoltage compare never changes switching
// - Supply-ok follows undervoltage compare hysteresis
// - Overvoltage drops supply-ok, regulation continues
// - Dead time: gates never on together
// - Internal soft-start steps 128 levels
// - No switching in soft-start until soft-start reaches feedback
`timescale 1ns/1ps
`default_nettype none
module bfp_fault_seq #(
  parameter int HICCUP_CYC = bfp_pkg::HIC_CYC // Hiccup delay, clocks
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire bfp_pkg::bfp_sense_t i_sense,
  output var bfp_pkg::bfp_gate_t o_gate,
  output logic o_ss_discharge,
  output logic o_uvt_sel_fb,
  output logic [6:0] o_ss_level,
  output logic o_ov_flag,
  output logic o_hiccup,
  output logic o_supply_ok_output_o,
  output logic o_supply_ok_output_oe
);
  import bfp_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Count of set bits in the event history
  function automatic logic [5:0] bfp_pop(input logic [CL_WIN-1:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int k = 0; k < CL_WIN; k++) begin
      n = n + {5'h00, v[k]};
    end
    return n;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  bfp_sense_t s1; // First stage, read only by s
  bfp_sense_t s; // Synchronised comparator levels

  // Two flops for every analog comparator
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= '0;
      s <= '0;
    end else if (i_ce) begin
      s1 <= i_sense;
      s <= s1;
    end
  end

  // ---------------------------------------------------------------
  // State and counters
  // ---------------------------------------------------------------
  bfp_state_t st; // Sequencer state
  bfp_state_t next_st; // Next state
  logic [TW-1:0] tmr; // Shared delay timer
  logic [7:0] ss_cnt; // Internal soft-start count
  logic [CL_WIN-1:0] cl_hist; // Sliding event history
  logic cl_q; // Previous current-limit level
  logic cl_term; // Pulse ended by current limit
  logic pwm_q; // Previous pwm level
  logic pb_ok; // Soft-start has caught feedback
  logic [1:0] blk; // Blanking counter
  logic [DW-1:0] ov_cnt; // Overvoltage deglitch count
  logic [DW-1:0] pg_cnt; // Supply-ok deglitch count
  logic pg; // Filtered supply-ok

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire st_ss = (st == S_SS);
  wire st_run = (st == S_RUN);
  wire st_hic = (st == S_HIC);
  wire st_nhic = (st == S_NHIC);
  wire st_tsd = (st == S_TSD);
  wire st_dly = (st == S_DLY);
  // Rising current limit is one event
  wire cl_evt = s.cl & ~cl_q;
  wire pwm_rise = s.pwm & ~pwm_q;
  wire [5:0] cl_num = bfp_pop(cl_hist);
  wire heavy = (cl_num >= 6'(CL_HEAVY));
  wire ss_done = ss_cnt[7]; // Count reached 128
  wire ss_step = st_ss & (tmr == TW'(SS_STEP_CYC - 1)) & ~ss_done;
  // Negative compare: raw overvoltage, low side on, blank over
  wire neg_hit = s.over_threshold_compare & o_gate.ls & (blk == 2'h0) & s.neg;
  wire sw_en = (st_ss & pb_ok) | st_run;
  wire kill = heavy | neg_hit | s.ot_hot | ~s.lockout_ok;
  wire tmr_dly = (tmr == TW'(EN_DLY_CYC - 1));
  wire tmr_hic = (tmr == TW'(HICCUP_CYC - 1));
  wire st_chg = (next_st != st);

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    unique case (st)
      S_OFF: begin
        if (s.lockout_ok) next_st = S_DLY;
      end
      S_DLY: begin
        if (tmr_dly) next_st = S_SS;
      end
      S_SS, S_RUN: begin
        if (heavy) begin
          next_st = S_HIC;
        end else if (neg_hit) begin
          next_st = S_NHIC;
        end else if (st_ss && ss_done) begin
          next_st = S_RUN;
        end
      end
      S_HIC, S_NHIC: begin
        if (tmr_hic) next_st = S_DLY; // Full restart
      end
      S_TSD: begin
        if (s.ot_cool) next_st = S_SS; // No latch
      end
      default: next_st = S_OFF;
    endcase
    // Lockout overrides all; over-temperature overrides all but S_OFF
    if (!s.lockout_ok) begin
      next_st = S_OFF;
    end else if (s.ot_hot && st != S_OFF) begin
      next_st = S_TSD;
    end
  end

  // ---------------------------------------------------------------
  // State register and timer
  // ---------------------------------------------------------------
  // Timer restarts on each state change
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= S_OFF;
      tmr <= '0;
    end else if (i_ce) begin
      st <= next_st;
      if (st_chg || ss_step) begin
        tmr <= '0;
      end else begin
        tmr <= tmr + TW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Soft-start count and prebias hold
  // ---------------------------------------------------------------
  // Count only in soft-start, hold in run, cleared elsewhere
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ss_cnt <= SS_RST;
      pb_ok <= 1'b0;
    end else if (i_ce) begin
      if (!(st_ss || st_run)) begin
        ss_cnt <= SS_RST;
        pb_ok <= 1'b0;
      end else begin
        if (ss_step) ss_cnt <= ss_cnt + 8'h01;
        if (s.ss_at_fb) pb_ok <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Current-limit history
  // ---------------------------------------------------------------
  // Shift one bit per clock so old events age out
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cl_hist <= '0;
      cl_q <= 1'b0;
      cl_term <= 1'b0;
      pwm_q <= 1'b0;
    end else if (i_ce) begin
      cl_q <= s.cl;
      pwm_q <= s.pwm;
      if (!sw_en || st_chg) begin
        cl_hist <= '0;
      end else begin
        cl_hist <= {cl_hist[CL_WIN-2:0], cl_evt};
      end
      // Pulse stays ended until next pwm rise
      if (cl_evt) begin
        cl_term <= 1'b1;
      end else if (pwm_rise) begin
        cl_term <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Gate enables with adaptive dead time
  // ---------------------------------------------------------------
  wire hs_want = sw_en & s.pwm & ~cl_term & ~cl_evt & ~kill;
  wire ls_want = sw_en & ~hs_want & ~kill;
  // Each side waits for the other to be off
  wire next_hs = hs_want & ~o_gate.ls & s.ls_off;
  wire next_ls = ls_want & ~o_gate.hs & ~next_hs & s.hs_off;
  wire ls_rise = next_ls & ~o_gate.ls;

  // Gate flops and comparator mux select
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gate <= '0;
      o_uvt_sel_fb <= 1'b0;
      blk <= 2'h0;
    end else if (i_ce) begin
      o_gate.hs <= next_hs;
      o_gate.ls <= next_ls;
      if (!sw_en) begin
        o_uvt_sel_fb <= 1'b0;
      end else if (next_hs) begin
        o_uvt_sel_fb <= 1'b1; // First pulse
      end
      if (ls_rise || pwm_rise) begin
        blk <= 2'(BLANK_CYC);
      end else if (blk != 2'h0) begin
        blk <= blk - 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Overvoltage deglitch
  // ---------------------------------------------------------------
  // Flag set after steady overvoltage, clear at once
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ov_cnt <= '0;
      o_ov_flag <= 1'b0;
    end else if (i_ce) begin
      if (!s.over_threshold_compare) begin
        ov_cnt <= '0;
        o_ov_flag <= 1'b0; // Below 113 %
      end else if (ov_cnt == DW'(OV_DG_CYC - 1)) begin
        o_ov_flag <= 1'b1;
      end else begin
        ov_cnt <= ov_cnt + DW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Supply-ok
  // ---------------------------------------------------------------
  // Raw condition; undervoltage compare gates only this
  wire pg_raw = (st_ss | st_run) & ss_done & s.uvt_good & ~o_ov_flag;

  // Change only after raw level differs for the whole deglitch
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pg_cnt <= '0;
      pg <= 1'b0;
    end else if (i_ce) begin
      if (pg_raw == pg) begin
        pg_cnt <= '0;
      end else if (pg_cnt == DW'(PG_DG_CYC - 1)) begin
        pg_cnt <= '0;
        pg <= pg_raw;
      end else begin
        pg_cnt <= pg_cnt + DW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_supply_ok_output_o <= 1'b0;
      o_supply_ok_output_oe <= 1'b1;
      o_ss_discharge <= 1'b1;
      o_hiccup <= 1'b0;
      o_ss_level <= 7'h00;
    end else if (i_ce) begin
      o_supply_ok_output_o <= 1'b0; // Open drain only pulls low
      o_supply_ok_output_oe <= ~pg;
      // Pull soft-start down outside soft-start and run
      o_ss_discharge <= ~(next_st == S_SS || next_st == S_RUN);
      o_hiccup <= (next_st == S_HIC) || (next_st == S_NHIC);
      o_ss_level <= ss_cnt[6:0] | {7{ss_done}}; // Hold top level once done
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  gate_overlap_a: assert property (!(o_gate.hs && o_gate.ls))
    else $error("both gates on");
  tsd_gates_a: assert property (i_ce && st_tsd |=> !o_gate.hs && !o_gate.ls)
    else $error("gate on in thermal shutdown");
  tsd_exit_a: assert property (st_tsd && s.ot_cool && s.lockout_ok && !s.ot_hot && i_ce
    |=> st == S_SS)
    else $error("no restart after cooling");
  light_cl_a: assert property (i_ce && cl_evt |=> !o_gate.hs)
    else $error("high side on after limit");
  heavy_cl_a: assert property (i_ce && heavy && s.lockout_ok && !s.ot_hot
    && (st_ss || st_run) |=> st_hic)
    else $error("no hiccup on heavy limit");
  hist_step_a: assert property (i_ce && cl_evt && sw_en && !st_chg
    |=> cl_hist[0])
    else $error("event not counted");
  hic_len_a: assert property (i_ce && st_hic && tmr_hic && s.lockout_ok
    && !s.ot_hot |=> st_dly && tmr == '0)
    else $error("hiccup end wrong");
  neg_cut_a: assert property (i_ce && neg_hit |=> !o_gate.ls)
    else $error("low side on after negative limit");
  neg_gate_a: assert property (neg_hit |-> s.over_threshold_compare && blk == 2'h0)
    else $error("negative limit outside window");
  ov_dg_a: assert property ($rose(o_ov_flag) |-> $past(ov_cnt) == DW'(OV_DG_CYC - 1))
    else $error("overvoltage deglitch short");
  pg_dg_a: assert property ($changed(pg) |-> $past(pg_cnt) == DW'(PG_DG_CYC - 1))
    else $error("supply-ok deglitch short");
  pg_cond_a: assert property ($fell(o_supply_ok_output_oe) |-> $past(ss_done && s.uvt_good, 2))
    else $error("supply-ok without soft-start done");
  uvt_sel_a: assert property ($rose(o_uvt_sel_fb) |-> o_gate.hs)
    else $error("mux switched before first pulse");
  prebias_a: assert property (i_ce && st_ss && !pb_ok |=> !o_gate.hs && !o_gate.ls)
    else $error("switching before soft-start reached feedback");
  restart_clr_a: assert property (i_ce && next_st == S_DLY && st != S_DLY
    |=> cl_hist == '0 && tmr == '0)
    else $error("restart left counters");

  heavy_c: cover property (heavy ##[1:4] st_hic);
  tsd_c: cover property (st_tsd ##[1:20] st_ss);
  pg_c: cover property ($rose(o_supply_ok_output_oe));
  neg_c: cover property (neg_hit ##1 st_nhic);
endmodule // bfp_fault_seq
`default_nettype wire

// File: bench/bfp_stage_model.sv
// Power stage model: gate-off sensing and switch-node comparator
`timescale 1ns/1ps
`default_nettype none
module bfp_stage_model (
  input wire logic i_mclk,
  input wire logic i_slow,
  input wire logic i_neg_fault,
  input wire bfp_pkg::bfp_gate_t i_gate,
  output logic o_hs_off,
  output logic o_ls_off,
  output logic o_neg
);
  import bfp_pkg::*;
  logic [2:0] hs_pipe = 3'h7; // High-side off history
  logic [2:0] ls_pipe = 3'h7; // Low-side off history
  // ---------------------------------------------------------------
  // Switch turn-off delay
  // ---------------------------------------------------------------
  // A slow stage reports off only after three quiet clocks
  always_ff @(posedge i_mclk) begin
    hs_pipe <= {hs_pipe[1:0], ~i_gate.hs};
    ls_pipe <= {ls_pipe[1:0], ~i_gate.ls};
  end
  assign o_hs_off = i_slow ? &hs_pipe : hs_pipe[0];
  assign o_ls_off = i_slow ? &ls_pipe : ls_pipe[0];
  // Node rises above ground only while the low side conducts
  assign o_neg = i_neg_fault & ~ls_pipe[0];
endmodule // bfp_stage_model
`default_nettype wire

// File: bench/bfp_fault_seq_test.sv
// Self-checking bench for the buck fault sequencer
`timescale 1ns/1ps
`default_nettype none
module bfp_fault_seq_test;
  import bfp_pkg::*;
  // ---------------------------------------------------------------
  // Settings and signals
  // ---------------------------------------------------------------
  localparam int HIC = 64; // Shortened hiccup delay
  localparam int T_PG = SS_STEPS * SS_STEP_CYC + PG_DG_CYC; // Ramp then filter
  typedef struct packed {
    logic [5:0] mask;
    logic [5:0] val;
  } bfp_note_t;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic under_threshold_compare, over_threshold_compare, cl, hot, cool, lk, pwm, atfb, negf, slow, pwm_run;
  logic pwm_set; // Modulator level while not free running
  logic ce; // Clock enable into the design
  logic hs_off, ls_off, neg, dis, sel_fb, ovf, hic, pg_o, pg_oe;
  logic [6:0] ss_lvl;
  logic [5:0] obs; // {hs, ls, discharge, ov, hiccup, supply_ok_output_oe}
  bfp_sense_t sense;
  bfp_gate_t gate;
  bfp_note_t exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  int hs_rises = 0;
  int pcnt = 0;
  int seed = 32'hB171B184;
  always #20 i_mclk = ~i_mclk;
  assign sense = {under_threshold_compare, over_threshold_compare, cl, neg, hot, cool, lk, pwm, atfb, hs_off, ls_off};
  assign obs = {gate.hs, gate.ls, dis, ovf, hic, pg_oe};
  bfp_fault_seq #(.HICCUP_CYC(HIC)) bfp_fault_seq_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_ce(ce), .i_sense(sense), .o_gate(gate), .o_ss_discharge(dis), .o_uvt_sel_fb(sel_fb),
    .o_ss_level(ss_lvl), .o_ov_flag(ovf), .o_hiccup(hic), .o_supply_ok_output_o(pg_o),
    .o_supply_ok_output_oe(pg_oe));
  bfp_stage_model bfp_stage_model_i (.i_mclk(i_mclk), .i_slow(slow), .i_neg_fault(negf),
    .i_gate(gate), .o_hs_off(hs_off), .o_ls_off(ls_off), .o_neg(neg));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask
  task automatic note(input logic [5:0] m, input logic [5:0] v);
    exp_q.push_back({m, v});
  endtask
  // Counted interval must fall inside its window
  task automatic check_cnt(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // Direct compare of a registered output level
  task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for an output pattern, then note it for the watcher
  task automatic wait_for(input logic [5:0] m, input logic [5:0] v, input int lim,
                          output int n);
    n = 0;
    while ((obs & m) !== v && n < lim) begin
      tick(1);
      n++;
    end
    note(m, v);
  endtask
  // Five current-limit pulses at a given spacing
  task automatic cl_burst(input int gap);
    for (int i = 0; i < 5; i++) begin
      cl = 1'b1;
      tick(1);
      cl = 1'b0;
      if (i < 4) tick(gap - 1);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Stimulus and watchers
  // ---------------------------------------------------------------
  // Modulator demand toggles every ten clocks while running
  // Long enough for a slow stage to clear both dead times
  always @(posedge i_mclk) begin
    #2;
    if (pwm_run) begin
      pcnt = (pcnt + 1) % 10;
      if (pcnt == 0) pwm = ~pwm;
    end else begin
      pwm = pwm_set;
    end
  end
  always @(posedge gate.hs) hs_rises++;
  // Each queued note is compared against the settled outputs
  always @(negedge i_mclk) begin
    bfp_note_t e;
    if (gate === 2'b11) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gate, 2'h1);
    end
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      total_checks++;
      if ((obs & e.mask) !== e.val) begin
        err_total++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, obs & e.mask, e.val);
      end
    end
  end
  initial begin
    #(40 * 20000);
    err_total++;
    close_out();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    int r;
    logic [5:0] snap;
    {under_threshold_compare, over_threshold_compare, cl, hot, cool, lk, pwm_set, atfb, negf, slow, pwm_run} = '0;
    ce = 1'b1;
    under_threshold_compare = 1'b1;
    tick(6);
    note(6'h3F, 6'h09);
    i_rst_n = 1'b1;
    lk = 1'b1;
    wait_for(6'h08, 6'h00, 2000, n);
    check_cnt(n, EN_DLY_CYC, EN_DLY_CYC + 6);
    check_eq({1'b0, ss_lvl}, 8'h00);
    check_eq({7'h00, sel_fb}, 8'h00);
    note(6'h31, 6'h01);
    wait_for(6'h01, 6'h00, 3000, n);
    check_cnt(n, T_PG - 2, T_PG + 6);
    check_eq({1'b0, ss_lvl}, 8'(SS_STEPS - 1));
    check_eq({7'h00, sel_fb}, 8'h00);
    check_eq({7'h00, pg_o}, 8'h00);
    atfb = 1'b1;
    pwm_set = 1'b1;
    wait_for(6'h30, 6'h20, 20, n);
    check_eq({7'h00, sel_fb}, 8'h01);
    cl = 1'b1;
    tick(1);
    cl = 1'b0;
    wait_for(6'h20, 6'h00, 8, n);
    check_cnt(n, 1, 4);
    wait_for(6'h30, 6'h10, 12, n);
    slow = 1'($random(seed));
    pwm_run = 1'b1;
    tick(40);
    r = hs_rises;
    under_threshold_compare = 1'b0;
    wait_for(6'h03, 6'h01, 700, n);
    check_cnt(n, PG_DG_CYC, PG_DG_CYC + 5);
    check_cnt(hs_rises - r, 20, 1000);
    under_threshold_compare = 1'b1;
    wait_for(6'h01, 6'h00, 700, n);
    check_cnt(n, PG_DG_CYC, PG_DG_CYC + 5);
    negf = 1'b1;
    tick(40);
    note(6'h02, 6'h00);
    negf = 1'b0;
    cl_burst(9 + ($random(seed) & 3));
    tick(4);
    note(6'h02, 6'h00);
    tick(40);
    cl_burst(2 + ($random(seed) & 3));
    wait_for(6'h32, 6'h02, 10, n);
    check_cnt(n, 1, 5);
    wait_for(6'h02, 6'h00, 200, n);
    check_cnt(n, HIC - 2, HIC + 4);
    wait_for(6'h20, 6'h20, 2000, n);
    check_cnt(n, EN_DLY_CYC, EN_DLY_CYC + 40);
    wait_for(6'h01, 6'h00, 1500, n);
    over_threshold_compare = 1'b1;
    wait_for(6'h04, 6'h04, 400, n);
    check_cnt(n, OV_DG_CYC, OV_DG_CYC + 4);
    wait_for(6'h03, 6'h01, 700, n);
    check_cnt(n, PG_DG_CYC, PG_DG_CYC + 5);
    over_threshold_compare = 1'b0;
    wait_for(6'h04, 6'h00, 6, n);
    over_threshold_compare = 1'b1;
    negf = 1'b1;
    wait_for(6'h32, 6'h02, 40, n);
    check_cnt(n, 1, 30);
    negf = 1'b0;
    over_threshold_compare = 1'b0;
    wait_for(6'h02, 6'h00, 200, n);
    check_cnt(n, HIC - 2, HIC + 4);
    wait_for(6'h20, 6'h20, 2000, n);
    hot = 1'b1;
    wait_for(6'h38, 6'h08, 8, n);
    hot = 1'b0;
    cool = 1'b1;
    wait_for(6'h08, 6'h00, 8, n);
    tick(2);
    cool = 1'b0;
    wait_for(6'h20, 6'h20, 40, n);
    // Enable low freezes everything, lockout included
    ce = 1'b0;
    snap = obs;
    lk = 1'b0;
    tick(10);
    note(6'h3F, snap);
    ce = 1'b1;
    wait_for(6'h3F, 6'h09, 8, n);
    check_cnt(n, 3, 4);
    close_out();
  end
endmodule // bfp_fault_seq_test
`default_nettype wire
